//--- hdl/bps_cfg.svh
// timing constants for the button power state controller
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH
`define BPS_CLK_HZ        250000000
`define BPS_SEARCH_MIN    15
`define BPS_PAUSE_MIN     15
`define BPS_HOLD_SEC      5
`define BPS_DEBOUNCE_US   10
`define BPS_BLINK_MS      250
`define BPS_PULSE_MS      100
`define BPS_SEC_CYC       (`BPS_CLK_HZ)
`define BPS_US_CYC        (`BPS_CLK_HZ / 1000000)
`define BPS_MS_CYC        (`BPS_CLK_HZ / 1000)
`define BPS_TICK_CYC      (`BPS_MS_CYC)
`define BPS_DEBOUNCE_CYC  (`BPS_DEBOUNCE_US * `BPS_US_CYC)
`define BPS_SEARCH_MS     (`BPS_SEARCH_MIN * 60 * 1000)
`define BPS_PAUSE_MS      (`BPS_PAUSE_MIN * 60 * 1000)
`define BPS_HOLD_MS       (`BPS_HOLD_SEC * 1000)
`endif

//--- hdl/bps_pkg.sv
// types shared by the button power state controller
`default_nettype none
package bps_pkg;
    // operational states
    typedef enum logic [2:0] {
        BPS_OFF      = 3'h0,
        BPS_SEARCH   = 3'h1,
        BPS_ENABLED  = 3'h2,
        BPS_SWEEPING = 3'h3,
        BPS_PAUSED   = 3'h4,
        BPS_RESET    = 3'h5
    } bps_state_e;
endpackage
`default_nettype wire

//--- hdl/bps_button.sv
// button synchroniser, debouncer and short/long press classifier
`include "bps_cfg.svh"
`default_nettype none
module bps_button #(
    parameter int DEBOUNCE_CYC = `BPS_DEBOUNCE_CYC,
    parameter int HOLD_MS      = `BPS_HOLD_MS
) (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic tick_ms,     // one-cycle pulse per millisecond
    input  wire logic button_pin,  // raw button, high when pressed
    output logic      short_press, // pulse at release of a short press
    output logic      long_hold    // pulse once when hold passes the limit
);
    // ************************************************************
    // synchroniser and debounce
    // ************************************************************
    logic        sync1;            // first stage, read only by sync2
    logic        sync2;
    logic        stable;           // debounced level
    logic [31:0] db_cnt;
    logic [31:0] hold_ms;          // ms the button has been held
    logic        long_done;        // long hold already reported
    logic        next_stable;
    logic [31:0] next_db_cnt;
    logic [31:0] next_hold_ms;
    logic        next_long_done;
    logic        next_short;
    logic        next_long;

    // next values for debounce and press timing
    always_comb begin
        next_stable    = stable;
        next_db_cnt    = 32'h0;
        next_hold_ms   = hold_ms;
        next_long_done = long_done;
        next_short     = 1'b0;
        next_long      = 1'b0;
        if (sync2 != stable) begin
            // level must stay changed for the whole debounce window
            next_db_cnt = db_cnt + 32'h1;
            if (db_cnt >= 32'(DEBOUNCE_CYC - 1)) begin
                next_stable = sync2;
                next_db_cnt = 32'h0;
            end
        end
        if (stable) begin
            if (tick_ms && !long_done) begin
                next_hold_ms = hold_ms + 32'h1;
            end
            // past the hold limit: report long hold once
            if (hold_ms >= 32'(HOLD_MS) && !long_done) begin
                next_long      = 1'b1;
                next_long_done = 1'b1;
            end
        end
        if (stable && !next_stable) begin
            // act on a short press only at release, under the limit
            next_short     = !long_done && !next_long;
            next_hold_ms   = 32'h0;
            next_long_done = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1       <= 1'b0;
            sync2       <= 1'b0;
            stable      <= 1'b0;
            db_cnt      <= 32'h0;
            hold_ms     <= 32'h0;
            long_done   <= 1'b0;
            short_press <= 1'b0;
            long_hold   <= 1'b0;
        end else begin
            sync1       <= button_pin;
            sync2       <= sync1;
            stable      <= next_stable;
            db_cnt      <= next_db_cnt;
            hold_ms     <= next_hold_ms;
            long_done   <= next_long_done;
            short_press <= next_short;
            long_hold   <= next_long;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    short_excl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(short_press && long_hold))
        else $error("short press and long hold together");
    short_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        short_press |-> $past(stable) && !stable)
        else $error("short press not at release");
endmodule
`default_nettype wire

//--- hdl/bps_ctrl.sv
// operational state controller with button, link, sweep and LED handling
`include "bps_cfg.svh"
`default_nettype none
// Overview of operation
// - press from off starts network search, LED blinks
// - search without network 15 minutes powers off
// - link loss while enabled, sweeping or paused restarts search, LED blinks
// - network formed enters sweep enabled, LED on
// - trigger takes one sweep, LED pulses briefly
// - short press while searching, enabled or sweeping pauses, LED off
// - paused over 15 minutes powers off
// - hold over 5 seconds forces reset, then search
// - low battery disables new measurement starts
module bps_ctrl #(
    parameter int SEARCH_MS   = `BPS_SEARCH_MS,
    parameter int PAUSE_MS    = `BPS_PAUSE_MS,
    parameter int HOLD_MS     = `BPS_HOLD_MS,
    parameter int TICK_CYC    = `BPS_TICK_CYC,
    parameter int DEBOUNCE_CYC = `BPS_DEBOUNCE_CYC,
    parameter int BLINK_MS    = `BPS_BLINK_MS,
    parameter int PULSE_MS    = `BPS_PULSE_MS
) (
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    input  wire logic               button_pin,   // raw push button, high pressed
    input  wire logic               link_up,      // network formed (async)
    input  wire logic               battery_low,  // battery near end (async)
    input  wire logic               sweep_trig,   // trigger pulse from link logic
    input  wire logic               sweep_done,   // measurement finished pulse
    output logic                    power_on,     // keeps unit powered
    output logic                    radio_search, // radio told to seek network
    output logic                    sweep_start,  // one-cycle measurement start
    output logic                    meas_disabled, // low battery disabled flag
    output logic                    led,          // button LED
    output bps_pkg::bps_state_e     state         // current operational state
);
    import bps_pkg::*;

    // ************************************************************
    // millisecond tick divider
    // ************************************************************
    logic [31:0] div_cnt;
    logic        tick_ms;          // one-cycle enable per ms
    logic [31:0] next_div_cnt;
    logic        next_tick_ms;

    // next divider values
    always_comb begin
        next_tick_ms = 1'b0;
        next_div_cnt = div_cnt + 32'h1;
        if (div_cnt >= 32'(TICK_CYC - 1)) begin
            next_div_cnt = 32'h0;
            next_tick_ms = 1'b1;
        end
    end

    // divider registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_cnt <= 32'h0;
            tick_ms <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            tick_ms <= next_tick_ms;
        end
    end

    // ************************************************************
    // input synchronisers and button
    // ************************************************************
    logic link_s1;                 // first stages, read only by second
    logic link_s2;
    logic link_s3;                 // delayed copy for the loss edge
    logic link_lost;               // link level fell this cycle
    logic batt_s1;
    logic batt_s2;
    logic short_press;
    logic long_hold;

    // two-flop synchronisers for pin levels
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            link_s1 <= 1'b0;
            link_s2 <= 1'b0;
            link_s3 <= 1'b0;
            batt_s1 <= 1'b0;
            batt_s2 <= 1'b0;
        end else begin
            link_s1 <= link_up;
            link_s2 <= link_s1;
            link_s3 <= link_s2;
            batt_s1 <= battery_low;
            batt_s2 <= batt_s1;
        end
    end

    // falling edge of the synchronised link level
    assign link_lost = link_s3 && !link_s2;

    // debounced press classifier
    bps_button #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC),
        .HOLD_MS      (HOLD_MS)
    ) u_button (
        .clk_sys     (clk_sys),
        .resetn      (resetn),
        .tick_ms     (tick_ms),
        .button_pin  (button_pin),
        .short_press (short_press),
        .long_hold   (long_hold)
    );

    // ************************************************************
    // state machine and timers
    // ************************************************************
    bps_state_e  next_state;
    logic [31:0] idle_ms;          // ms spent in the current state, used in search and pause
    logic [31:0] next_idle_ms;
    logic [31:0] led_ms;           // blink phase / pulse timer
    logic [31:0] next_led_ms;
    logic        next_sweep_start;
    logic        next_led;

    // next state
    always_comb begin
        next_state       = state;
        next_idle_ms     = idle_ms;
        next_sweep_start = 1'b0;
        if (tick_ms) begin
            next_idle_ms = idle_ms + 32'h1;
        end
        unique case (state)
            BPS_OFF: begin
                if (short_press) begin
                    next_state = BPS_SEARCH;
                end
            end
            BPS_SEARCH: begin
                if (link_s2) begin
                    next_state = BPS_ENABLED;
                end else if (idle_ms >= 32'(SEARCH_MS)) begin
                    next_state = BPS_OFF;
                end else if (short_press) begin
                    next_state = BPS_PAUSED;
                end
            end
            BPS_ENABLED: begin
                if (short_press) begin
                    next_state = BPS_PAUSED;
                end else if (sweep_trig && !batt_s2) begin
                    next_state       = BPS_SWEEPING;
                    next_sweep_start = 1'b1;
                end
            end
            BPS_SWEEPING: begin
                if (sweep_done) begin
                    next_state = BPS_ENABLED;
                end else if (short_press) begin
                    next_state = BPS_PAUSED;
                end
            end
            BPS_PAUSED: begin
                if (idle_ms >= 32'(PAUSE_MS)) begin
                    next_state = BPS_OFF;
                end else if (short_press) begin
                    next_state = link_s2 ? BPS_ENABLED : BPS_SEARCH;
                end
            end
            BPS_RESET: begin
                next_state = BPS_SEARCH;
            end
            default: begin
                next_state = BPS_OFF;
            end
        endcase
        // link loss restarts search; a pause entered without link stays paused
        if ((!link_s2 && state inside {BPS_ENABLED, BPS_SWEEPING})
                || (link_lost && state == BPS_PAUSED)) begin
            next_state = BPS_SEARCH;
        end
        if (long_hold) begin
            next_state       = BPS_RESET;
            next_sweep_start = 1'b0;
        end
        if (next_state != state) begin
            next_idle_ms = 32'h0;
        end
    end

    // next LED and timers
    always_comb begin
        next_led_ms = led_ms;
        if (tick_ms) begin
            next_led_ms = led_ms + 32'h1;
        end
        if (next_sweep_start || next_state != state) begin
            next_led_ms = 32'h0;
        end
        unique case (next_state)
            BPS_SEARCH, BPS_RESET: begin
                // wrap after a full period so on and off phases are equal
                if (next_led_ms >= 32'(2 * BLINK_MS)) begin
                    next_led_ms = 32'h0;
                end
                next_led = (next_led_ms < 32'(BLINK_MS));
            end
            BPS_ENABLED: next_led = 1'b1;
            BPS_SWEEPING: next_led = (next_led_ms >= 32'(PULSE_MS));
            default: next_led = 1'b0;
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state         <= BPS_OFF;
            idle_ms       <= 32'h0;
            led_ms        <= 32'h0;
            sweep_start   <= 1'b0;
            led           <= 1'b0;
            power_on      <= 1'b0;
            radio_search  <= 1'b0;
            meas_disabled <= 1'b0;
        end else begin
            state         <= next_state;
            idle_ms       <= next_idle_ms;
            led_ms        <= next_led_ms;
            sweep_start   <= next_sweep_start;
            led           <= next_led;
            power_on      <= (next_state != BPS_OFF);
            radio_search  <= (next_state == BPS_SEARCH);
            meas_disabled <= batt_s2;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    start_only_enabled_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sweep_start |-> $past(state) == BPS_ENABLED && state == BPS_SWEEPING)
        else $error("sweep started outside sweep enabled");
    no_sweep_lowbat_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sweep_start |-> !$past(batt_s2))
        else $error("sweep started on low battery");
    off_to_search_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_OFF && short_press && !long_hold) |=> state == BPS_SEARCH)
        else $error("press from off did not start search");
    link_loss_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_ENABLED && !link_s2 && !long_hold) |=> state == BPS_SEARCH)
        else $error("link loss did not restart search");
    enabled_led_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_ENABLED) |-> led)
        else $error("led not lit in sweep enabled");
    paused_led_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_PAUSED || state == BPS_OFF) |-> !led)
        else $error("led lit while paused or off");
    hold_reset_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        long_hold |=> state == BPS_RESET ##1 state == BPS_SEARCH)
        else $error("long hold did not reset into search");
    search_timeout_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_SEARCH && idle_ms >= 32'(SEARCH_MS) && !link_s2 && !long_hold)
        |=> state == BPS_OFF)
        else $error("search timeout did not power off");
    pause_timeout_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        (state == BPS_PAUSED && idle_ms >= 32'(PAUSE_MS) && !link_lost && !long_hold)
        |=> state == BPS_OFF)
        else $error("pause timeout did not power off");
    sweep_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sweep_start |-> !led)
        else $error("led not pulsed at sweep start");

    sweep_c: cover property (@(posedge clk_sys) disable iff (!resetn) sweep_start);
    pause_c: cover property (@(posedge clk_sys) disable iff (!resetn) state == BPS_PAUSED);
    reset_c: cover property (@(posedge clk_sys) disable iff (!resetn) state == BPS_RESET);
    timeout_c: cover property (@(posedge clk_sys) disable iff (!resetn)
        state == BPS_SEARCH ##1 state == BPS_OFF);
endmodule
`default_nettype wire

//--- testbench/bps_pc_model.sv
// far-side model: pc application with its wireless adapter
`default_nettype none
module bps_pc_model (
    input  wire logic clk_sys,     // system clock
    input  wire logic sweep_start, // measurement start from the unit
    output logic      link_up,     // network formed
    output logic      sweep_trig,  // one-cycle trigger pulse
    output logic      sweep_done   // one-cycle end of measurement
);
    timeunit 1ns;
    timeprecision 1ps;

    int done_wait; // cycles from start to end of a measurement

    // idle: no network, no pulses
    initial begin
        link_up = 1'b0;
        sweep_trig = 1'b0;
        sweep_done = 1'b0;
        done_wait = 1;
    end

    // network forms only while adapter and application both run
    task automatic app_run(input logic on);
        @(negedge clk_sys);
        link_up = on;
    endtask

    // one trigger, exactly one clock wide
    task automatic trigger();
        @(negedge clk_sys);
        sweep_trig = 1'b1;
        @(negedge clk_sys);
        sweep_trig = 1'b0;
    endtask

    // measurement ends done_wait cycles after its start
    always @(posedge clk_sys) begin
        if (sweep_start === 1'b1) begin
            repeat (done_wait) @(negedge clk_sys);
            sweep_done = 1'b1;
            @(negedge clk_sys);
            sweep_done = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- testbench/bps_ctrl_tb.sv
// self-checking bench for the button power state controller
`default_nettype none
module bps_ctrl_tb;
    import bps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TICK = 4;  // clocks per millisecond tick
    localparam int TMO  = 50; // search and pause limit, ms
    localparam int HOLD = 20; // long hold limit, ms

    logic       clk_sys, resetn, button_pin, battery_low;
    logic       link_up, sweep_trig, sweep_done;
    logic       power_on, radio_search, sweep_start, meas_disabled, led;
    bps_state_e state;
    bps_state_e prev;    // state seen at the last falling edge
    bps_state_e exp_q[$]; // planned state changes, oldest first
    int         n_fail, n_tests;

    bps_ctrl #(.SEARCH_MS(TMO), .PAUSE_MS(TMO), .HOLD_MS(HOLD), .TICK_CYC(TICK),
        .DEBOUNCE_CYC(3), .BLINK_MS(3), .PULSE_MS(2)) bps_ctrl_i (
        .clk_sys(clk_sys), .resetn(resetn), .button_pin(button_pin),
        .link_up(link_up), .battery_low(battery_low), .sweep_trig(sweep_trig),
        .sweep_done(sweep_done), .power_on(power_on), .radio_search(radio_search),
        .sweep_start(sweep_start), .meas_disabled(meas_disabled), .led(led),
        .state(state));

    bps_pc_model bps_pc_model_i (.clk_sys(clk_sys), .sweep_start(sweep_start),
        .link_up(link_up), .sweep_trig(sweep_trig), .sweep_done(sweep_done));

    // ***************
    // tasks
    // ***************
    // compare a state value
    task automatic chk_state(input string what, input bps_state_e e, input bps_state_e g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %0h seen %0h", what, e, g);
        end
    endtask

    // compare a single bit
    task automatic chk_bit(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b seen %b", what, e, g);
        end
    endtask

    // wait for falling edges
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // press for cyc clocks; short holds must not act before release
    task automatic press(input int cyc);
        bps_state_e s0;
        @(negedge clk_sys);
        s0 = state;
        button_pin = 1'b1;
        ticks(cyc);
        chk_state("state while held", s0, state);
        button_pin = 1'b0;
    endtask

    // bounded wait for a state
    task automatic wait_state(input bps_state_e e, input int max);
        int k;
        k = 0;
        while (state !== e && k < max) begin
            @(negedge clk_sys);
            k++;
        end
        chk_state("state reached", e, state);
    endtask

    // led must toggle several times in 60 clocks
    task automatic chk_blink();
        int n;
        logic l0;
        n = 0;
        l0 = led;
        repeat (60) begin
            @(negedge clk_sys);
            if (led !== l0) n++;
            l0 = led;
        end
        chk_bit("led blinking", 1'b1, n >= 3);
    endtask

    // verdict and end of run
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ***************
    // clock, monitor, watchdog
    // ***************
    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // every state change must match the oldest planned one
    always @(negedge clk_sys) begin
        if (resetn === 1'b1 && state !== prev) begin
            if (exp_q.size() == 0) chk_state("unplanned state", prev, state);
            else chk_state("state change", exp_q.pop_front(), state);
        end
        if (sweep_start === 1'b1) chk_bit("start outside sweep", 1'b1, state === BPS_SWEEPING);
        prev = state;
    end

    // cut a hang short
    initial begin
        repeat (10000) @(posedge clk_sys);
        n_fail++;
        print_verdict();
    end

    // ***************
    // main sequence
    // ***************
    initial begin
        void'($urandom(32'h8c76));
        resetn = 1'b0;
        button_pin = 1'b0;
        battery_low = 1'b0;
        prev = BPS_OFF;
        n_fail = 0;
        n_tests = 0;
        ticks(5);
        chk_state("reset state", BPS_OFF, state);
        chk_bit("outputs in reset", 1'b0, power_on | radio_search | sweep_start | led);
        resetn = 1'b1;
        // glitch ignored, then short press from off
        press(1);
        ticks(20);
        exp_q.push_back(BPS_SEARCH);
        press($urandom_range(10, 40));
        wait_state(BPS_SEARCH, 20);
        chk_bit("radio search", 1'b1, radio_search & power_on);
        chk_blink();
        // no network: off after the search limit, not before
        exp_q.push_back(BPS_OFF);
        ticks(TMO * TICK - 90);
        chk_state("search before limit", BPS_SEARCH, state);
        wait_state(BPS_OFF, 60);
        chk_bit("power after timeout", 1'b0, power_on);
        // search then network forms
        exp_q.push_back(BPS_SEARCH);
        exp_q.push_back(BPS_ENABLED);
        press($urandom_range(10, 40));
        bps_pc_model_i.app_run(1'b1);
        wait_state(BPS_ENABLED, 40);
        chk_bit("led steady", 1'b1, led);
        // back-to-back sweeps with random measurement length
        repeat (3) begin
            bps_pc_model_i.done_wait = $urandom_range(1, 8);
            exp_q.push_back(BPS_SWEEPING);
            exp_q.push_back(BPS_ENABLED);
            bps_pc_model_i.trigger();
            chk_bit("sweep start", 1'b1, sweep_start);
            chk_bit("led pulse", 1'b0, led);
            wait_state(BPS_ENABLED, 20);
        end
        // low battery blocks the trigger
        battery_low = 1'b1;
        ticks(4);
        chk_bit("measure disabled", 1'b1, meas_disabled);
        bps_pc_model_i.trigger();
        ticks(10);
        battery_low = 1'b0;
        ticks(4);
        chk_bit("measure enabled", 1'b0, meas_disabled);
        // pause, trigger ignored, resume
        exp_q.push_back(BPS_PAUSED);
        press($urandom_range(10, 40));
        wait_state(BPS_PAUSED, 20);
        chk_bit("led paused", 1'b0, led);
        bps_pc_model_i.trigger();
        ticks(10);
        exp_q.push_back(BPS_ENABLED);
        press($urandom_range(10, 40));
        wait_state(BPS_ENABLED, 20);
        // link loss restarts search
        exp_q.push_back(BPS_SEARCH);
        bps_pc_model_i.app_run(1'b0);
        wait_state(BPS_SEARCH, 10);
        chk_blink();
        // pause from search, then pause limit
        exp_q.push_back(BPS_PAUSED);
        press($urandom_range(10, 40));
        wait_state(BPS_PAUSED, 20);
        exp_q.push_back(BPS_OFF);
        ticks(TMO * TICK - 30);
        chk_state("pause before limit", BPS_PAUSED, state);
        wait_state(BPS_OFF, 60);
        // long hold: reset, search again, release does nothing
        exp_q.push_back(BPS_SEARCH);
        press($urandom_range(10, 40));
        wait_state(BPS_SEARCH, 20);
        exp_q.push_back(BPS_RESET);
        exp_q.push_back(BPS_SEARCH);
        @(negedge clk_sys);
        button_pin = 1'b1;
        ticks(HOLD * TICK + 20);
        button_pin = 1'b0;
        ticks(30);
        chk_state("search after reset", BPS_SEARCH, state);
        chk_blink();
        bps_pc_model_i.trigger();
        ticks(10);
        chk_bit("all changes seen", 1'b1, exp_q.size() == 0);
        print_verdict();
    end
endmodule
`default_nettype wire
